// file: dagu_top.sv
// Data address generation unit: index, modify, base, length and pointer files, two generators.
// Assumes decode drives one request per generator per cycle; requests are synchronous to clock_in.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: Two independent generators, four index/modify/base/length sets, nine pointers.
// RQ2: Index registers are 32-bit unsigned, for 16- and 32-bit accesses only.
// RQ3: Modify registers are 32-bit signed post-modify steps.
// RQ4: Post-modify drives the old index then adds the modifier.
// RQ5: Base and length are 32-bit, tied to the same-numbered index.
// RQ6: Pointer updates are always linear, never wrapped; the code also applies the bit-reversed update to pointers.
// RQ7: Pointers address 8-, 16- and 32-bit accesses.
// RQ8: Supervisor stack pointer access in user mode raises an exception.
// RQ9: Address registers have no reset; software loads lengths before use.
// RQ10: Zero length disables wrapping for its index.
// RQ11: Each register loads only on its own write; base leaves index alone.
// RQ12: Offset mode adds offset to pointer without write-back.
// RQ13: Byte addresses; accesses aligned to their size.
// RQ14: Misaligned final address raises an alignment exception.
// RQ15: Auto step is 1, 2 or 4 by access size.
// RQ16: Loaded bytes are zero- or sign-extended as selected.
// RQ17: Index modifiers: modify register or immediate; pointer modifiers: immediate or pointer.
// RQ18: Pointer file is six general, frame and stack pointers, 32-bit.
// RQ19: Pointer arithmetic leaves arithmetic flags unchanged.
// RQ20: Stack alias picks user or supervisor pointer by mode.
// RQ21: User stack alias is accepted only in supervisor mode.
// RQ22: Frame and stack pointers serve as ordinary address sources.
// RQ23: Bit-reversed carry update; stored address not reversed.
// RQ24: Modify without memory access.
// RQ25: Both generators compute and write back in the same cycle.
module dagu_top (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    // Mode
    input  wire logic        supervisor_in,
    // Generator 0 request
    input  wire logic        g0_valid_in,
    input  wire logic [2:0]  g0_mode_in,
    input  wire logic [1:0]  g0_size_in,
    input  wire logic        g0_use_index_in,
    input  wire logic [3:0]  g0_sel_in,
    input  wire logic        g0_mod_is_reg_in,
    input  wire logic [3:0]  g0_mod_sel_in,
    input  wire logic [31:0] g0_imm_in,
    // Generator 1 request
    input  wire logic        g1_valid_in,
    input  wire logic [2:0]  g1_mode_in,
    input  wire logic [1:0]  g1_size_in,
    input  wire logic        g1_use_index_in,
    input  wire logic [3:0]  g1_sel_in,
    input  wire logic        g1_mod_is_reg_in,
    input  wire logic [3:0]  g1_mod_sel_in,
    input  wire logic [31:0] g1_imm_in,
    // Register write port
    input  wire logic        wr_en_in,
    input  wire logic [2:0]  wr_file_in,
    input  wire logic [3:0]  wr_sel_in,
    input  wire logic [31:0] wr_data_in,
    // Register read port
    input  wire logic        rd_en_in,
    input  wire logic [2:0]  rd_file_in,
    input  wire logic [3:0]  rd_sel_in,
    // Load extension
    input  wire logic        ld_valid_in,
    input  wire logic [1:0]  ld_size_in,
    input  wire logic        ld_sign_in,
    input  wire logic [31:0] ld_raw_in,
    // Results
    output logic      [31:0] g0_addr_out,
    output logic             g0_valid_out,
    output logic             g0_align_exc_out,
    output logic      [31:0] g1_addr_out,
    output logic             g1_valid_out,
    output logic             g1_align_exc_out,
    output logic      [31:0] rd_data_out,
    output logic             priv_exc_out,
    output logic             illegal_exc_out,
    output logic      [31:0] ld_data_out,
    output logic             ld_valid_out
);
    // Register file selector values for wr_file_in / rd_file_in
    localparam logic [2:0] F_IDX = 3'h0;
    localparam logic [2:0] F_MOD = 3'h1;
    localparam logic [2:0] F_BAS = 3'h2;
    localparam logic [2:0] F_LEN = 3'h3;
    localparam logic [2:0] F_PTR = 3'h4;

    typedef enum logic [1:0] {
        DAGU_USER = 2'b01,
        DAGU_SUPV = 2'b10
    } dagu_mode_type;

    // No reset on address state, contents undefined until software loads them
    logic [31:0] idx_q [dagu_pkg::NUM_IDX]; // RQ1 RQ2 RQ9
    logic [31:0] mod_q [dagu_pkg::NUM_IDX]; // RQ3
    logic [31:0] bas_q [dagu_pkg::NUM_IDX]; // RQ5
    logic [31:0] len_q [dagu_pkg::NUM_IDX]; // RQ5
    logic [31:0] ptr_q [9];                 // RQ18: 0..5, frame 6, supv sp 7, user sp 8
    dagu_mode_type mode_state;

    function automatic logic [3:0] ptr_slot(input logic [3:0] sel, input dagu_mode_type m);
        if (sel == dagu_pkg::PSEL_SP_ALIAS && m == DAGU_USER) begin
            ptr_slot = dagu_pkg::PSEL_USER_SP; // RQ20
        end else begin
            ptr_slot = sel; // RQ20 RQ22
        end
    endfunction : ptr_slot

    // User alias only from supervisor; out-of-range selectors are illegal
    function automatic logic sel_bad(input logic [3:0] sel, input logic ix, input dagu_mode_type m);
        if (ix) begin
            sel_bad = sel[3:2] != 2'b00;
        end else begin
            sel_bad = (sel > dagu_pkg::PSEL_USER_SP)
                      || (sel == dagu_pkg::PSEL_USER_SP && m == DAGU_USER); // RQ21
        end
    endfunction : sel_bad

    assign mode_state = supervisor_in ? DAGU_SUPV : DAGU_USER;

    logic [31:0] src   [2];
    logic [31:0] modv  [2];
    logic [31:0] basv  [2];
    logic [31:0] lenv  [2];
    logic [31:0] addr  [2];
    logic [31:0] wb    [2];
    logic        wb_en [2];
    logic        mis   [2];
    logic        szb   [2];
    logic        bad   [2];
    logic        go    [2];
    logic [3:0]  slot  [2];
    logic        vld   [2];
    logic [2:0]  md    [2];
    logic [1:0]  sz    [2];
    logic        ix    [2];
    logic [3:0]  sel   [2];
    logic        mreg  [2];
    logic [3:0]  msel  [2];
    logic [31:0] imm   [2];

    always_comb begin
        vld[0] = g0_valid_in;   md[0] = g0_mode_in;   sz[0] = g0_size_in;   ix[0] = g0_use_index_in;
        sel[0] = g0_sel_in;     mreg[0] = g0_mod_is_reg_in; msel[0] = g0_mod_sel_in; imm[0] = g0_imm_in;
        vld[1] = g1_valid_in;   md[1] = g1_mode_in;   sz[1] = g1_size_in;   ix[1] = g1_use_index_in;
        sel[1] = g1_sel_in;     mreg[1] = g1_mod_is_reg_in; msel[1] = g1_mod_sel_in; imm[1] = g1_imm_in;
    end

    for (genvar g = 0; g < 2; g++) begin : g_gen // RQ25
        always_comb begin
            slot[g] = ptr_slot(sel[g], mode_state);
            bad[g]  = sel_bad(sel[g], ix[g], mode_state);
            if (ix[g]) begin
                src[g]  = idx_q[sel[g][1:0]];
                basv[g] = bas_q[sel[g][1:0]]; // RQ5
                lenv[g] = len_q[sel[g][1:0]];
                modv[g] = mreg[g] ? mod_q[msel[g][1:0]] : imm[g]; // RQ17
            end else begin
                src[g]  = bad[g] ? dagu_pkg::ZERO_WORD : ptr_q[slot[g]];
                basv[g] = dagu_pkg::ZERO_WORD;
                lenv[g] = dagu_pkg::ZERO_WORD; // RQ6
                modv[g] = (mreg[g] && msel[g] <= dagu_pkg::PSEL_USER_SP)
                          ? ptr_q[ptr_slot(msel[g], mode_state)] : imm[g]; // RQ17
            end
            go[g] = vld[g] && !bad[g] && !mis[g] && !szb[g];
        end

        dagu_agen u_agen (
            .mode_in      (md[g]),
            .size_in      (sz[g]),
            .use_index_in (ix[g]),
            .src_in       (src[g]),
            .mod_in       (modv[g]),
            .base_in      (basv[g]),
            .length_in    (lenv[g]),
            .addr_out     (addr[g]),
            .wb_out       (wb[g]),
            .wb_en_out    (wb_en[g]),
            .misalign_out (mis[g]),
            .size_bad_out (szb[g])
        );
    end

    // Register updates, no reset; generator 1 write-back wins on a clash, then generator 0, then the move
    always_ff @(posedge clock_in) begin
        if (wr_en_in && !sel_bad(wr_sel_in, wr_file_in != F_PTR, mode_state)) begin
            unique case (wr_file_in) // RQ11
                F_IDX:   idx_q[wr_sel_in[1:0]] <= wr_data_in;
                F_MOD:   mod_q[wr_sel_in[1:0]] <= wr_data_in;
                F_BAS:   bas_q[wr_sel_in[1:0]] <= wr_data_in;
                F_LEN:   len_q[wr_sel_in[1:0]] <= wr_data_in;
                F_PTR:   ptr_q[ptr_slot(wr_sel_in, mode_state)] <= wr_data_in; // RQ8 RQ19
                default: ;
            endcase
        end
        for (int g = 0; g < 2; g++) begin
            if (go[g] && wb_en[g]) begin
                if (ix[g]) begin
                    idx_q[sel[g][1:0]] <= wb[g];
                end else begin
                    ptr_q[slot[g]] <= wb[g]; // RQ6 RQ7
                end
            end
        end
    end

    // Address outputs and exception flags
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            g0_addr_out      <= 32'h0000_0000;
            g1_addr_out      <= 32'h0000_0000;
            g0_valid_out     <= 1'b0;
            g1_valid_out     <= 1'b0;
            g0_align_exc_out <= 1'b0;
            g1_align_exc_out <= 1'b0;
        end else begin
            g0_addr_out      <= addr[0];
            g1_addr_out      <= addr[1];
            g0_valid_out     <= go[0] && md[0] != dagu_pkg::MD_MODIFY; // RQ24
            g1_valid_out     <= go[1] && md[1] != dagu_pkg::MD_MODIFY;
            g0_align_exc_out <= vld[0] && !bad[0] && mis[0]; // RQ14
            g1_align_exc_out <= vld[1] && !bad[1] && mis[1];
        end
    end

    // Privilege and illegal-use exceptions, register reads
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out     <= 32'h0000_0000;
            priv_exc_out    <= 1'b0;
            illegal_exc_out <= 1'b0;
        end else begin
            priv_exc_out <= ((rd_en_in && rd_file_in == F_PTR && rd_sel_in == dagu_pkg::PSEL_USER_SP)
                          || (wr_en_in && wr_file_in == F_PTR && wr_sel_in == dagu_pkg::PSEL_USER_SP)
                          || (g0_valid_in && !g0_use_index_in && g0_sel_in == dagu_pkg::PSEL_USER_SP)
                          || (g1_valid_in && !g1_use_index_in && g1_sel_in == dagu_pkg::PSEL_USER_SP))
                          && mode_state == DAGU_USER; // RQ8 RQ21
            illegal_exc_out <= (vld[0] && szb[0]) || (vld[1] && szb[1]); // RQ2
            rd_data_out <= 32'h0000_0000;
            if (rd_en_in && !sel_bad(rd_sel_in, rd_file_in != F_PTR, mode_state)) begin
                unique case (rd_file_in)
                    F_IDX:   rd_data_out <= idx_q[rd_sel_in[1:0]];
                    F_MOD:   rd_data_out <= mod_q[rd_sel_in[1:0]];
                    F_BAS:   rd_data_out <= bas_q[rd_sel_in[1:0]];
                    F_LEN:   rd_data_out <= len_q[rd_sel_in[1:0]];
                    F_PTR:   rd_data_out <= ptr_q[ptr_slot(rd_sel_in, mode_state)]; // RQ20
                    default: rd_data_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Load zero or sign extension
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ld_data_out  <= 32'h0000_0000;
            ld_valid_out <= 1'b0;
        end else begin
            ld_valid_out <= ld_valid_in;
            unique case (ld_size_in) // RQ16
                dagu_pkg::SZ_BYTE: ld_data_out <= {{24{ld_sign_in & ld_raw_in[7]}}, ld_raw_in[7:0]};
                dagu_pkg::SZ_HALF: ld_data_out <= {{16{ld_sign_in & ld_raw_in[15]}}, ld_raw_in[15:0]};
                default:           ld_data_out <= ld_raw_in;
            endcase
        end
    end
endmodule : dagu_top
`default_nettype wire

// file: dagu_pkg.sv
// Package for the data address generation unit: register selectors, modes, sizes, constants.
// Assumes a 32-bit byte-addressed core with one clock.
package dagu_pkg;
    localparam int unsigned ADDR_W        = 32;
    localparam int unsigned NUM_IDX       = 4;
    localparam int unsigned NUM_PTR_SEL   = 16;
    // Pointer selector codes: 0..5 general, then frame, alias, user alias
    localparam logic [3:0]  PSEL_FRAME    = 4'h6;
    localparam logic [3:0]  PSEL_SP_ALIAS = 4'h7;
    localparam logic [3:0]  PSEL_USER_SP  = 4'h8;
    localparam logic [3:0]  PSEL_LAST_GEN = 4'h5;
    // Access sizes
    localparam logic [1:0]  SZ_BYTE       = 2'h0;
    localparam logic [1:0]  SZ_HALF       = 2'h1;
    localparam logic [1:0]  SZ_WORD       = 2'h2;
    localparam logic [1:0]  SZ_NONE       = 2'h3;
    // Address modes
    localparam logic [2:0]  MD_PLAIN      = 3'h0;
    localparam logic [2:0]  MD_OFFSET     = 3'h1;
    localparam logic [2:0]  MD_POST_INC   = 3'h2;
    localparam logic [2:0]  MD_POST_DEC   = 3'h3;
    localparam logic [2:0]  MD_POST_REG   = 3'h4;
    localparam logic [2:0]  MD_POST_IMM   = 3'h5;
    localparam logic [2:0]  MD_BITREV     = 3'h6;
    localparam logic [2:0]  MD_MODIFY     = 3'h7;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

    // Step for auto increment / decrement by access size
    function automatic logic [31:0] dagu_size_step(input logic [1:0] sz);
        unique case (sz)
            SZ_BYTE: dagu_size_step = 32'h0000_0001;
            SZ_HALF: dagu_size_step = 32'h0000_0002;
            SZ_WORD: dagu_size_step = 32'h0000_0004;
            default: dagu_size_step = 32'h0000_0000;
        endcase
    endfunction : dagu_size_step

    // High when the address is not aligned to the access size
    function automatic logic dagu_misaligned(input logic [31:0] a, input logic [1:0] sz);
        unique case (sz)
            SZ_HALF: dagu_misaligned = a[0];
            SZ_WORD: dagu_misaligned = |a[1:0];
            default: dagu_misaligned = 1'b0;
        endcase
    endfunction : dagu_misaligned
endpackage : dagu_pkg

// file: dagu_circ.sv
// Circular wrap of an updated index against its base/length pair.
// Assumes a step magnitude not above the length.
`timescale 1ns/1ps
`default_nettype none
module dagu_circ (
    // Operands
    input  wire logic [31:0] index_in,
    input  wire logic [31:0] step_in,
    input  wire logic [31:0] base_in,
    input  wire logic [31:0] length_in,
    // Result
    output logic      [31:0] next_out
);
    logic [31:0] sum;
    logic [31:0] top;
    always_comb begin
        sum = index_in + step_in;
        top = base_in + length_in;
        next_out = sum;
        if (length_in != dagu_pkg::ZERO_WORD) begin // RQ10
            if (!step_in[31] && sum >= top) begin
                next_out = sum - length_in;
            end else if (step_in[31] && sum < base_in) begin
                next_out = sum + length_in;
            end
        end
    end
endmodule : dagu_circ
`default_nettype wire

// file: dagu_agen.sv
// One address generator: forms the access address and the write-back value.
// Assumes the top module supplies operand values already selected.
`timescale 1ns/1ps
`default_nettype none
module dagu_agen (
    // Request
    input  wire logic [2:0]  mode_in,
    input  wire logic [1:0]  size_in,
    input  wire logic        use_index_in,
    input  wire logic [31:0] src_in,
    input  wire logic [31:0] mod_in,
    input  wire logic [31:0] base_in,
    input  wire logic [31:0] length_in,
    // Result
    output logic      [31:0] addr_out,
    output logic      [31:0] wb_out,
    output logic             wb_en_out,
    output logic             misalign_out,
    output logic             size_bad_out
);
    logic [31:0] step;
    logic [31:0] circ_next;
    logic [31:0] rev_sum;
    logic [31:0] rev_src;
    logic [31:0] rev_mod;
    logic [31:0] stepped;

    // Index updates wrap; pointer updates never do
    dagu_circ u_circ (
        .index_in  (src_in),
        .step_in   (step),
        .base_in   (base_in),
        .length_in (use_index_in ? length_in : dagu_pkg::ZERO_WORD), // RQ6
        .next_out  (circ_next)
    );

    always_comb begin
        step = dagu_pkg::ZERO_WORD;
        unique case (mode_in)
            dagu_pkg::MD_POST_INC: step = dagu_pkg::dagu_size_step(size_in); // RQ15
            dagu_pkg::MD_POST_DEC: step = -dagu_pkg::dagu_size_step(size_in); // RQ15
            dagu_pkg::MD_POST_REG,
            dagu_pkg::MD_POST_IMM,
            dagu_pkg::MD_MODIFY:   step = mod_in; // RQ3 RQ17
            default:               step = dagu_pkg::ZERO_WORD;
        endcase
        // Reverse-carry add: reverse, add, reverse back
        rev_src = {<<{src_in}};
        rev_mod = {<<{mod_in}};
        rev_sum = {<<{rev_src + rev_mod}}; // RQ23
        stepped = circ_next;
        addr_out = src_in; // RQ4
        wb_out = src_in;
        wb_en_out = 1'b0;
        unique case (mode_in)
            dagu_pkg::MD_OFFSET: begin
                addr_out = src_in + mod_in; // RQ12
            end
            dagu_pkg::MD_POST_INC, dagu_pkg::MD_POST_DEC,
            dagu_pkg::MD_POST_REG, dagu_pkg::MD_POST_IMM: begin
                wb_out = stepped; // RQ4
                wb_en_out = 1'b1;
            end
            dagu_pkg::MD_BITREV: begin
                wb_out = rev_sum; // RQ23
                wb_en_out = 1'b1;
            end
            dagu_pkg::MD_MODIFY: begin
                wb_out = stepped; // RQ24
                wb_en_out = 1'b1;
            end
            default: ;
        endcase
        misalign_out = (mode_in != dagu_pkg::MD_MODIFY)
                       && dagu_pkg::dagu_misaligned(addr_out, size_in); // RQ13 RQ14
        size_bad_out = use_index_in && (size_in == dagu_pkg::SZ_BYTE)
                       && (mode_in != dagu_pkg::MD_MODIFY); // RQ2
    end
endmodule : dagu_agen
`default_nettype wire

// file: dagu_sva.sv
// Checker for dagu_top: answer timing, refusals and load extension.
// Assumes binding to dagu_top; one clock, reset high.
`timescale 1ns/1ps
`default_nettype none
module dagu_sva (
    // Clock and reset
    input wire logic        clock_in,
    input wire logic        sys_rst_in,
    // Requests
    input wire logic        supervisor_in,
    input wire logic        g0_valid_in,
    input wire logic [2:0]  g0_mode_in,
    input wire logic [1:0]  g0_size_in,
    input wire logic        g0_use_index_in,
    input wire logic [3:0]  g0_sel_in,
    input wire logic        g1_valid_in,
    input wire logic [1:0]  g1_size_in,
    input wire logic        ld_valid_in,
    input wire logic [1:0]  ld_size_in,
    input wire logic        ld_sign_in,
    input wire logic [31:0] ld_raw_in,
    // Results
    input wire logic [31:0] g0_addr_out,
    input wire logic        g0_valid_out,
    input wire logic        g0_align_exc_out,
    input wire logic [31:0] g1_addr_out,
    input wire logic        g1_valid_out,
    input wire logic        g1_align_exc_out,
    input wire logic        priv_exc_out,
    input wire logic        illegal_exc_out,
    input wire logic [31:0] ld_data_out,
    input wire logic        ld_valid_out
);
    logic [31:0] raw_q;
    always_ff @(posedge clock_in) begin
        raw_q <= ld_raw_in;
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    a_modify_no_access: assert property (g0_valid_in && g0_mode_in == dagu_pkg::MD_MODIFY |=> !g0_valid_out)
        else $error("modify-only request gave an access");
    a_word_aligned: assert property (g0_valid_out && $past(g0_size_in) == dagu_pkg::SZ_WORD |-> g0_addr_out[1:0] == 2'h0)
        else $error("word access accepted on unaligned address");
    a_half_aligned: assert property (g1_valid_out && $past(g1_size_in) == dagu_pkg::SZ_HALF |-> !g1_addr_out[0])
        else $error("half access accepted on odd address");
    a_exc_refuses: assert property (g0_align_exc_out |-> !g0_valid_out)
        else $error("alignment fault with access accepted");
    a_byte_index: assert property (g0_valid_in && g0_use_index_in && g0_size_in == dagu_pkg::SZ_BYTE
        && g0_mode_in != dagu_pkg::MD_MODIFY |=> illegal_exc_out && !g0_valid_out)
        else $error("byte access through index not refused");
    a_user_alias: assert property (g0_valid_in && !g0_use_index_in && g0_sel_in == dagu_pkg::PSEL_USER_SP
        && !supervisor_in |=> priv_exc_out && !g0_valid_out)
        else $error("user alias in user mode not refused");
    a_zero_ext: assert property (ld_valid_in && !ld_sign_in && ld_size_in == dagu_pkg::SZ_BYTE
        |=> ld_valid_out && ld_data_out == {24'h0, raw_q[7:0]})
        else $error("byte zero extension wrong");
    a_sign_ext: assert property (ld_valid_in && ld_sign_in && ld_size_in == dagu_pkg::SZ_HALF
        |=> ld_valid_out && ld_data_out == {{16{raw_q[15]}}, raw_q[15:0]})
        else $error("half sign extension wrong");
    a_idle_quiet: assert property (!g1_valid_in |=> !g1_valid_out && !g1_align_exc_out)
        else $error("generator 1 answered without request");
endmodule : dagu_sva
bind dagu_top dagu_sva u_sva (.*);
`default_nettype wire

// file: dagu_mem_model.sv
// Data memory stand-in: returns a fixed word one cycle after each access.
// Assumes access_in is the generator's accepted-access pulse.
`timescale 1ns/1ps
`default_nettype none
module dagu_mem_model (
    // Clock
    input  wire logic        clock_in,
    // Access
    input  wire logic        access_in,
    output logic      [31:0] rdata_out
);
    // Outside the answer cycle the bus shows the inverse of the last value
    always_ff @(posedge clock_in) begin
        if (access_in) begin
            rdata_out <= 32'h0000_8080;
        end else begin
            rdata_out <= ~rdata_out;
        end
    end
endmodule : dagu_mem_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for dagu_top: table of accesses, then hand-written cases.
// Assumes outputs answer on the taking edge itself and are checked 1 ns after it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
    typedef struct packed {
        logic [2:0] md; logic [1:0] sz; logic ix; logic [3:0] sel; logic mr; logic [3:0] ms;
        logic [31:0] imm; logic [31:0] ea; logic ev; logic ex; logic [31:0] ew;
    } dagu_row_type;
    logic        clock_in, sys_rst_in, supervisor_in, wr_en_in, rd_en_in, ld_valid_in, ld_sign_in;
    logic        g0_valid_in, g0_use_index_in, g0_mod_is_reg_in, g1_valid_in, g1_use_index_in, g1_mod_is_reg_in;
    logic [2:0]  g0_mode_in, g1_mode_in, wr_file_in, rd_file_in;
    logic [1:0]  g0_size_in, g1_size_in, ld_size_in;
    logic [3:0]  g0_sel_in, g0_mod_sel_in, g1_sel_in, g1_mod_sel_in, wr_sel_in, rd_sel_in;
    logic [31:0] g0_imm_in, g1_imm_in, wr_data_in, ld_raw_in, mem_data;
    logic [31:0] g0_addr_out, g1_addr_out, rd_data_out, ld_data_out;
    logic        g0_valid_out, g0_align_exc_out, g1_valid_out, g1_align_exc_out;
    logic        priv_exc_out, illegal_exc_out, ld_valid_out;
    int          bad_count, checks_done;
    localparam logic [31:0] LX [4] = '{32'h0000_0080, 32'hffff_ff80, 32'h0000_8080, 32'hffff_8080};
    dagu_row_type rows [14] = '{
        '{3'h2, 2'h2, 1'h1, 4'h0, 1'h0, 4'h0, 32'h0, 32'h100, 1'h1, 1'h0, 32'h104},
        '{3'h4, 2'h2, 1'h1, 4'h0, 1'h1, 4'h1, 32'h0, 32'h104, 1'h1, 1'h0, 32'hfc},
        '{3'h3, 2'h1, 1'h1, 4'h0, 1'h0, 4'h0, 32'h0, 32'hfc, 1'h1, 1'h0, 32'hfa},
        '{3'h0, 2'h2, 1'h1, 4'h0, 1'h0, 4'h0, 32'h0, 32'h0, 1'h0, 1'h1, 32'hfa},
        '{3'h5, 2'h1, 1'h1, 4'h0, 1'h0, 4'h0, 32'h2, 32'hfa, 1'h1, 1'h0, 32'hfc},
        '{3'h2, 2'h0, 1'h0, 4'h0, 1'h0, 4'h0, 32'h0, 32'h13, 1'h1, 1'h0, 32'h14},
        '{3'h1, 2'h2, 1'h0, 4'h0, 1'h0, 4'h0, 32'h10, 32'h24, 1'h1, 1'h0, 32'h14},
        '{3'h4, 2'h2, 1'h0, 4'h1, 1'h1, 4'h2, 32'h0, 32'h1000, 1'h1, 1'h0, 32'h1010},
        '{3'h7, 2'h3, 1'h0, 4'h1, 1'h0, 4'h0, 32'h4, 32'h0, 1'h0, 1'h0, 32'h1014},
        '{3'h2, 2'h2, 1'h1, 4'h1, 1'h0, 4'h0, 32'h0, 32'h20c, 1'h1, 1'h0, 32'h200},
        '{3'h3, 2'h2, 1'h0, 4'h6, 1'h0, 4'h0, 32'h0, 32'h2000, 1'h1, 1'h0, 32'h1ffc},
        '{3'h2, 2'h2, 1'h0, 4'h7, 1'h0, 4'h0, 32'h0, 32'h3000, 1'h1, 1'h0, 32'h3004},
        '{3'h6, 2'h2, 1'h1, 4'h2, 1'h1, 4'h0, 32'h0, 32'h8, 1'h1, 1'h0, 32'h4},
        '{3'h2, 2'h0, 1'h1, 4'h0, 1'h0, 4'h0, 32'h0, 32'h0, 1'h0, 1'h0, 32'hfc}};
    dagu_top DUT (.*);
    dagu_mem_model u_mem (.clock_in(clock_in), .access_in(g0_valid_out), .rdata_out(mem_data));
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    task tick;
        @(posedge clock_in);
        #1;
    endtask : tick
    task wr(input logic [2:0] f, input logic [3:0] s, input logic [31:0] d);
        wr_en_in = 1'b1; wr_file_in = f; wr_sel_in = s; wr_data_in = d;
        tick;
    endtask : wr
    task req(input logic [2:0] md, input logic [1:0] sz, input logic ix, input logic [3:0] sel);
        g0_mode_in = md; g0_size_in = sz; g0_use_index_in = ix; g0_sel_in = sel; g0_mod_is_reg_in = 1'b0;
        g0_valid_in = 1'b1;
    endtask : req
    task run(input dagu_row_type r);
        req(r.md, r.sz, r.ix, r.sel);
        g0_mod_is_reg_in = r.mr; g0_mod_sel_in = r.ms; g0_imm_in = r.imm;
        tick;
        g0_valid_in = 1'b0; rd_en_in = 1'b1; rd_file_in = r.ix ? 3'h0 : 3'h4; rd_sel_in = r.sel;
        if (r.ev) `CHK(g0_addr_out, r.ea)
        `CHK(g0_valid_out, r.ev)
        `CHK(g0_align_exc_out, r.ex)
        tick;
        rd_en_in = 1'b0;
        `CHK(rd_data_out, r.ew)
    endtask : run
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    initial begin
        #40000;
        bad_count++;
        give_verdict;
    end
    initial begin
        bad_count = 0; checks_done = 0; sys_rst_in = 1'b1; supervisor_in = 1'b1;
        {wr_en_in, rd_en_in, ld_valid_in, ld_sign_in, g0_valid_in, g1_valid_in} = 6'h0;
        {g0_use_index_in, g0_mod_is_reg_in, g1_use_index_in, g1_mod_is_reg_in} = 4'h0;
        {g0_mode_in, g1_mode_in, wr_file_in, rd_file_in} = 12'h0;
        {g0_size_in, g1_size_in, ld_size_in} = 6'h0;
        {g0_sel_in, g0_mod_sel_in, g1_sel_in, g1_mod_sel_in, wr_sel_in, rd_sel_in} = 24'h0;
        {g0_imm_in, g1_imm_in, wr_data_in, ld_raw_in} = 128'h0;
        repeat (8) @(posedge clock_in);
        #1;
        `CHK({g0_valid_out, g1_valid_out, priv_exc_out, ld_valid_out}, 4'h0)
        sys_rst_in = 1'b0;
        tick;
        wr(3'h0, 4'h0, 32'h100); wr(3'h1, 4'h1, 32'hffff_fff8); wr(3'h2, 4'h0, 32'h0); wr(3'h3, 4'h0, 32'h0);
        wr(3'h0, 4'h1, 32'h20c); wr(3'h2, 4'h1, 32'h200); wr(3'h3, 4'h1, 32'h10); wr(3'h0, 4'h2, 32'h8);
        wr(3'h1, 4'h0, 32'h8); wr(3'h2, 4'h2, 32'h0); wr(3'h3, 4'h2, 32'h0); wr(3'h4, 4'h0, 32'h13);
        wr(3'h4, 4'h1, 32'h1000); wr(3'h4, 4'h2, 32'h10); wr(3'h4, 4'h6, 32'h2000); wr(3'h4, 4'h7, 32'h3000);
        wr(3'h4, 4'h8, 32'h4000);
        wr_en_in = 1'b0;
        foreach (rows[i]) run(rows[i]);
        // Both generators in one cycle
        req(dagu_pkg::MD_POST_INC, dagu_pkg::SZ_WORD, 1'b1, 4'h0);
        g1_mode_in = dagu_pkg::MD_POST_INC; g1_size_in = dagu_pkg::SZ_HALF; g1_sel_in = 4'h0; g1_valid_in = 1'b1;
        tick;
        g0_valid_in = 1'b0; g1_valid_in = 1'b0;
        `CHK({g0_addr_out, g1_addr_out}, {32'hfc, 32'h14})
        `CHK({g0_valid_out, g1_valid_out, g1_align_exc_out, illegal_exc_out}, 4'hc)
        wr(3'h2, 4'h0, 32'h500);
        wr_en_in = 1'b0;
        run('{3'h0, 2'h2, 1'h1, 4'h0, 1'h0, 4'h0, 32'h0, 32'h100, 1'h1, 1'h0, 32'h100});
        run('{3'h0, 2'h1, 1'h0, 4'h0, 1'h0, 4'h0, 32'h0, 32'h16, 1'h1, 1'h0, 32'h16});
        supervisor_in = 1'b0;
        run('{3'h2, 2'h2, 1'h0, 4'h7, 1'h0, 4'h0, 32'h0, 32'h4000, 1'h1, 1'h0, 32'h4004});
        req(dagu_pkg::MD_PLAIN, dagu_pkg::SZ_WORD, 1'b0, dagu_pkg::PSEL_USER_SP);
        tick;
        g0_valid_in = 1'b0; rd_en_in = 1'b1; rd_file_in = 3'h4; rd_sel_in = dagu_pkg::PSEL_USER_SP;
        `CHK({priv_exc_out, g0_valid_out}, 2'h2)
        tick;
        rd_en_in = 1'b0;
        `CHK({priv_exc_out, rd_data_out}, {1'b1, 32'h0})
        supervisor_in = 1'b1;
        for (int k = 0; k < 4; k++) begin
            req(dagu_pkg::MD_PLAIN, dagu_pkg::SZ_WORD, 1'b0, 4'h1);
            tick;
            g0_valid_in = 1'b0;
            tick;
            ld_valid_in = 1'b1; ld_size_in = k[1] ? dagu_pkg::SZ_HALF : dagu_pkg::SZ_BYTE;
            ld_sign_in = k[0]; ld_raw_in = mem_data;
            tick;
            ld_valid_in = 1'b0;
            `CHK({ld_valid_out, ld_data_out}, {1'b1, LX[k]})
        end
        give_verdict;
    end
endmodule : tb_top
`default_nettype wire
